// ===== hw/pcd_consts.svh
// Constants for the duty/control register block of one modulator channel.
// Assumes byte addressing on a 32-bit classic Wishbone bus.
`ifndef PCD_CONSTS_SVH
`define PCD_CONSTS_SVH

// ==========================================================
// Register byte offsets
`define PCD_OFS_CONTROL 8'h00
`define PCD_OFS_DUTY_HI 8'h04
`define PCD_OFS_DUTY_LO 8'h08

// ==========================================================
// Control register fields
`define PCD_CTL_ON_BIT 7
`define PCD_CTL_READBACK_BIT 5
`define PCD_CTL_INVERT_BIT 4

// ==========================================================
// Duty lower bits field position
`define PCD_DLO_MSB 7
`define PCD_DLO_LSB 6

// ==========================================================
// Reset values
`define PCD_CTL_RESET 8'h00
`define PCD_PHASE_RESET 2'h0
`define PCD_DUTY_LATCH_RESET 10'h000

// ==========================================================
// Last clock phase within one timer increment at prescale 1:1
`define PCD_PHASE_LAST 2'h3

`endif

// ===== hw/pcd_pkg.sv
// Types for the modulator control block.
// Assumes pcd_consts.svh is on the include path.
package pcd_pkg;

  // ==========================================================
  // Wishbone request from the master
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [7:0] adr;
    logic [31:0] dat;
  } pcd_wb_req_t;

  // ==========================================================
  // Wishbone answer to the master
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
  } pcd_wb_rsp_t;

  // ==========================================================
  // Period timer view, from the shared timer on the same clock
  typedef struct packed {
    logic [7:0] count;
    logic restart;
    logic prescale_one;
    logic [1:0] prescale_bits;
  } pcd_timer_t;

  // ==========================================================
  // Whole state of the block
  typedef struct packed {
    logic channel_on;
    logic output_inversion;
    logic [7:0] duty_upper_bits;
    logic [1:0] duty_lower_bits;
    logic [9:0] duty_latched;
    logic [1:0] phase;
    logic active;
    logic pin;
    pcd_wb_rsp_t rsp;
  } pcd_state_t;

endpackage : pcd_pkg

// ===== hw/pcd_pwm_ctrl.sv
// Control and duty registers plus compare logic of one 10-bit modulator channel.
// Assumes a classic Wishbone master and a period timer on sys_clk.
`timescale 1ns/1ns
`include "pcd_consts.svh"

module pcd_pwm_ctrl (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire pcd_pkg::pcd_wb_req_t wb_req,
  output pcd_pkg::pcd_wb_rsp_t wb_rsp,
  input wire pcd_pkg::pcd_timer_t timer,
  output logic pwm_out
);
  import pcd_pkg::*;

  // ==========================================================
  // State
  pcd_state_t state_reg;
  pcd_state_t state_next;

  logic access;
  logic wr_strobe;
  logic [9:0] duty_buffered;
  logic [9:0] time_base;
  logic [7:0] control_read;
  logic [7:0] lower_read;
  logic [31:0] read_word;

  // ==========================================================
  // Bus decode
  assign access = wb_req.cyc && wb_req.stb;
  // Write lands on the edge where the master sees ack
  assign wr_strobe = access && wb_req.we && wb_req.sel[0] && state_reg.rsp.ack;

  assign duty_buffered = {state_reg.duty_upper_bits, state_reg.duty_lower_bits};

  // Timer increments every four clocks at 1:1, so phase fills the low bits
  assign time_base = {timer.count, timer.prescale_one ? state_reg.phase : timer.prescale_bits};

  // ==========================================================
  // Read data
  always_comb begin
    control_read = 8'h00;
    control_read[`PCD_CTL_ON_BIT] = state_reg.channel_on;
    control_read[`PCD_CTL_READBACK_BIT] = state_reg.pin;
    control_read[`PCD_CTL_INVERT_BIT] = state_reg.output_inversion;
    lower_read = 8'h00;
    lower_read[`PCD_DLO_MSB:`PCD_DLO_LSB] = state_reg.duty_lower_bits;
    case (wb_req.adr)
      `PCD_OFS_CONTROL: begin
        read_word = {24'h000000, control_read};
      end
      `PCD_OFS_DUTY_HI: begin
        read_word = {24'h000000, state_reg.duty_upper_bits};
      end
      `PCD_OFS_DUTY_LO: begin
        read_word = {24'h000000, lower_read};
      end
      default: begin
        // Unmapped offsets still ack, with zero data
        read_word = 32'h00000000;
      end
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    state_next = state_reg;

    // Bus answer: ack one cycle after the request, dropped the next
    state_next.rsp.ack = access && !state_reg.rsp.ack;
    if (access && !state_reg.rsp.ack && !wb_req.we) begin
      state_next.rsp.dat = read_word;
    end else begin
      state_next.rsp.dat = 32'h00000000;
    end

    // Register writes; unimplemented bits are simply not stored
    if (wr_strobe) begin
      case (wb_req.adr)
        `PCD_OFS_CONTROL: begin
          state_next.channel_on = wb_req.dat[`PCD_CTL_ON_BIT];
          state_next.output_inversion = wb_req.dat[`PCD_CTL_INVERT_BIT];
        end
        `PCD_OFS_DUTY_HI: begin
          state_next.duty_upper_bits = wb_req.dat[7:0];
        end
        `PCD_OFS_DUTY_LO: begin
          state_next.duty_lower_bits = wb_req.dat[`PCD_DLO_MSB:`PCD_DLO_LSB];
        end
        default: begin
          state_next.channel_on = state_reg.channel_on;
        end
      endcase
    end

    // Clock phase within one timer increment
    if (timer.restart || state_reg.phase == `PCD_PHASE_LAST) begin
      state_next.phase = `PCD_PHASE_RESET;
    end else begin
      state_next.phase = state_reg.phase + 2'h1;
    end

    // Compare engine
    if (timer.restart) begin
      // Double buffer: duty only takes effect at a period boundary
      state_next.duty_latched = duty_buffered;
      if (duty_buffered != 10'h000) begin
        state_next.active = 1'b1;
      end else begin
        state_next.active = 1'b0;
      end
    end else if (time_base == state_reg.duty_latched) begin
      // Equality only: a duty beyond the period is never reached
      state_next.active = 1'b0;
    end

    // Pin level; follows the control write at the same edge, so a disabled channel never shows a stale pulse
    if (state_next.channel_on) begin
      state_next.pin = state_next.active ^ state_next.output_inversion;
    end else begin
      state_next.pin = state_next.output_inversion;
    end
  end

  // ==========================================================
  // State register
  // Buffered duty registers are left out of reset so they survive it; duty_latched still resets
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      state_reg.channel_on <= 1'b0;
      state_reg.output_inversion <= 1'b0;
      state_reg.duty_upper_bits <= state_reg.duty_upper_bits;
      state_reg.duty_lower_bits <= state_reg.duty_lower_bits;
      state_reg.duty_latched <= `PCD_DUTY_LATCH_RESET;
      state_reg.phase <= `PCD_PHASE_RESET;
      state_reg.active <= 1'b0;
      state_reg.pin <= 1'b0;
      state_reg.rsp <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  // ==========================================================
  // Outputs
  assign wb_rsp = state_reg.rsp;
  assign pwm_out = state_reg.pin;

endmodule : pcd_pwm_ctrl

// ===== tb/pcd_pwm_ctrl_monitor.sv
// Checker for the modulator control block.
// Assumes it is bound to pcd_pwm_ctrl.
`timescale 1ns/1ns
module pcd_pwm_ctrl_monitor (
  input wire logic sys_clk,
  input wire logic rstn,
  input wire pcd_pkg::pcd_wb_req_t wb_req,
  input wire pcd_pkg::pcd_wb_rsp_t wb_rsp,
  input wire pcd_pkg::pcd_timer_t timer,
  input wire logic pwm_out
);
  import pcd_pkg::*;
  logic on_q;
  logic inv_q;
  logic rd;
  // ====================
  // Control shadow, so the pin can be judged
  assign rd = wb_rsp.ack && !wb_req.we && wb_req.adr == 8'h00;
  always_ff @(posedge sys_clk) begin
    if (!rstn) begin
      on_q <= 1'b0;
      inv_q <= 1'b0;
    end else if (wb_rsp.ack && wb_req.we && wb_req.sel[0] && wb_req.adr == 8'h00) begin
      on_q <= wb_req.dat[7];
      inv_q <= wb_req.dat[4];
    end
  end
  // ====================
  // Properties
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  sequence s_req;
    wb_req.cyc && wb_req.stb && !wb_rsp.ack;
  endsequence
  sequence s_idle;
    on_q && $stable(on_q) && $stable(inv_q) && !timer.restart && !(wb_rsp.ack && wb_req.we) && pwm_out == inv_q;
  endsequence
  a_ack_once: assert property (s_req |=> wb_rsp.ack) else $error("ack missing");
  a_ack_pulse: assert property (wb_rsp.ack |=> !wb_rsp.ack) else $error("ack too long");
  a_dat_idle: assert property (!wb_rsp.ack |-> wb_rsp.dat == 32'h0) else $error("data without ack");
  a_dat_upper: assert property (wb_rsp.ack |-> wb_rsp.dat[31:8] == 24'h0) else $error("upper data");
  a_ctl_unused: assert property (rd |-> !wb_rsp.dat[6] && wb_rsp.dat[3:0] == 4'h0) else $error("ctl bits");
  a_out_readback: assert property (rd |-> wb_rsp.dat[5] == $past(pwm_out)) else $error("readback");
  a_off_level: assert property (!on_q |-> pwm_out == inv_q) else $error("off level");
  a_hold_idle: assert property (s_idle |=> pwm_out == $past(inv_q)) else $error("early set");
endmodule : pcd_pwm_ctrl_monitor

// ===== tb/pcd_pwm_ctrl_tb.sv
// Bench for the modulator control block.
// Assumes the checker module is compiled first.
`timescale 1ns/1ns
module pcd_pwm_ctrl_tb;
  import pcd_pkg::*;
  logic sys_clk = 1'b0;
  logic rstn = 1'b0;
  pcd_wb_req_t wb_req = '0;
  pcd_wb_rsp_t wb_rsp;
  pcd_timer_t timer = '0;
  logic pwm_out;
  logic [1:0] pre = 2'h0;
  logic pre_one = 1'b0;
  logic [7:0] q;
  int n_errors = 0;
  int num_checks = 0;
  pcd_pwm_ctrl pcd_pwm_ctrl_inst (.sys_clk(sys_clk), .rstn(rstn), .wb_req(wb_req), .wb_rsp(wb_rsp),
    .timer(timer), .pwm_out(pwm_out));
  initial forever #5 sys_clk = ~sys_clk;
  // ====================
  // Timer: four clocks a count, limit 3, so a period is 16 clocks
  // Restart rides the increment that clears the count, so phase 0 meets count 0
  always @(posedge sys_clk) begin
    pre <= pre + 2'h1;
    timer.prescale_one <= pre_one;
    timer.prescale_bits <= pre + 2'h1;
    timer.restart <= pre == 2'h2 && timer.count == 8'h03;
    if (pre == 2'h3) timer.count <= (timer.count == 8'h03) ? 8'h00 : timer.count + 8'h01;
  end
  // ====================
  // Shared tasks
  task summarize();
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task wb(input logic we, input logic [7:0] a, input logic [7:0] d, input logic [3:0] s);
    int i;
    @(posedge sys_clk);
    wb_req <= '{1'b1, 1'b1, we, s, a, {24'h0, d}};
    for (i = 0; i < 20 && wb_rsp.ack !== 1'b1; i++) @(posedge sys_clk);
    if (i == 20) n_errors++;
    if (i == 20) summarize();
    q = wb_rsp.dat[7:0];
    wb_req <= '0;
  endtask : wb
  task wrc(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e, input logic [3:0] s);
    wb(1'b1, a, d, s);
    wb(1'b0, a, 8'h00, 4'hF);
    chk({24'h0, q}, {24'h0, e});
  endtask : wrc
  // ====================
  // Scenarios
  task t_regs();
    wrc(8'h00, 8'h6F, 8'h00, 4'hF);
    wrc(8'h04, 8'hA5, 8'hA5, 4'hF);
    wrc(8'h08, 8'hFF, 8'hC0, 4'hF);
    wrc(8'h04, 8'h5A, 8'hA5, 4'hE);
    wrc(8'h0C, 8'h77, 8'h00, 4'hF);
  endtask : t_regs
  task t_off();
    wrc(8'h00, 8'h10, 8'h30, 4'hF);
    rstn <= 1'b0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    wb(1'b0, 8'h04, 8'h00, 4'hF);
    chk({24'h0, q}, 32'hA5);
    chk({31'h0, pwm_out}, 32'h0);
  endtask : t_off
  task t_duty(input logic [7:0] h, input logic [7:0] l, input logic v, input logic p, input int e);
    int hi;
    int i;
    pre_one <= p;
    wb(1'b1, 8'h04, h, 4'hF);
    wb(1'b1, 8'h08, l, 4'hF);
    wb(1'b1, 8'h00, {3'h4, v, 4'h0}, 4'hF);
    hi = 0;
    repeat (2) @(posedge sys_clk);
    for (i = 0; i < 40 && timer.restart !== 1'b1; i++) @(posedge sys_clk);
    if (i == 40) n_errors++;
    if (i == 40) summarize();
    repeat (16) begin
      @(posedge sys_clk);
      hi += int'(pwm_out !== v);
    end
    chk(hi, e);
  endtask : t_duty
  initial begin
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    t_regs();
    t_off();
    t_duty(8'h02, 8'h40, 1'b0, 1'b1, 10);
    t_duty(8'h00, 8'h00, 1'b1, 1'b1, 0);
    t_duty(8'hFF, 8'hC0, 1'b0, 1'b1, 16);
    t_duty(8'h01, 8'h80, 1'b1, 1'b0, 7);
    summarize();
  end
endmodule : pcd_pwm_ctrl_tb
bind pcd_pwm_ctrl pcd_pwm_ctrl_monitor pcd_pwm_ctrl_monitor_inst (.sys_clk(sys_clk), .rstn(rstn),
  .wb_req(wb_req), .wb_rsp(wb_rsp), .timer(timer), .pwm_out(pwm_out));
